//--- verilog/dcld_config_latch.sv
// Behaviour
// - Four config latch bytes; bytes 2 and 3 applied on reset exit
// - Reset-pin select: 0 GPIO, 1 external reset
// - Debug port select picks JTAG5/JTAG4/SWD/off
// - Select sets default protocol; gates JTAG entry
// - Debug enable grants debug access port
// - Debug disabled: access only via test mode
// - ECC bit: spare row bytes ECC or data
// - Lock key writable only without flash protection
// - Correct key plus reset locks everything out
// - Locked latch changes again only at asynchronous reset (arst_n)
module dcld_config_latch
#(
    parameter logic RESET_PIN_DEFAULT = 1'b0
)
(
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic              externalResetN,
    output dcld_pkg::dcld_cfg_s    appliedCfg,
    output logic                   sharedPinGpio,
    output logic                   warmResetActive,
    output logic                   jtag5Enable,
    output logic                   jtag4Enable,
    output logic                   swdEnable,
    output logic                   debugAccessGrant,
    output logic                   programAllowed,
    output logic                   jtagProgramEntry,
    output logic                   testModeActive,
    output logic [8:0]             rowLoadBytes
);

    // ---------------------------------------------------------------
    // Bus phase tracking
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BUS_IDLE,
        BUS_WRITE,
        BUS_RDWAIT,
        BUS_RDDONE
    } dcld_bus_e;

    dcld_bus_e           busSt_r;
    dcld_bus_e           busSt_nxt;
    logic [5:0]          regIdx_r;
    logic                mapped_r;
    logic                addrAccept;
    logic                wrStrobe;
    logic [31:0]         hrdata_r;

    // ---------------------------------------------------------------
    // Latch storage and applied state
    // ---------------------------------------------------------------
    logic [7:0]          latch_r [dcld_pkg::LATCH_BYTES];
    logic [31:0]         lockKey_r;
    logic                flashProt_r;
    logic                testMode_r;
    logic                startupPend_r;
    logic                captureNow;
    logic                softReset;
    dcld_pkg::dcld_cfg_s cfg_r;
    dcld_pkg::dcld_cfg_s cfgLive;

    // True when a word index hits the given register
    function automatic logic regHit(input logic [5:0] idx, input logic [5:0] target);
        regHit = (idx == target);
    endfunction : regHit

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------

    // Reads insert one wait state; writes complete with none
    // Limitation: hsize is ignored, every access is a word
    // Address phase is taken only when the bus is ready
    assign addrAccept = hsel && hready && htrans[1];
    assign wrStrobe   = (busSt_r == BUS_WRITE) && mapped_r;
    assign hreadyout  = (busSt_r != BUS_RDWAIT);
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_r;

    // Next bus phase
    always_comb
    begin
        busSt_nxt = busSt_r;
        case (busSt_r)
            BUS_IDLE, BUS_WRITE, BUS_RDDONE:
            begin
                if (addrAccept)
                begin
                    busSt_nxt = hwrite ? BUS_WRITE : BUS_RDWAIT;
                end
                else
                begin
                    busSt_nxt = BUS_IDLE;
                end
            end
            BUS_RDWAIT:
            begin
                busSt_nxt = BUS_RDDONE;
            end
            default:
            begin
                busSt_nxt = BUS_IDLE;
            end
        endcase
    end

    // Bus phase register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busSt_r <= BUS_IDLE;
        end
        else
        begin
            busSt_r <= busSt_nxt;
        end
    end

    // Address capture; unmapped addresses read zero, writes dropped
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regIdx_r <= 6'h00;
            mapped_r <= 1'b0;
        end
        else if (addrAccept)
        begin
            regIdx_r <= haddr[7:2];
            mapped_r <= (haddr[31:8] == 24'h00_0000) && (haddr[7:2] <= dcld_pkg::IDX_STATUS);
        end
    end

    // Read data sampled in the wait cycle so a preceding write shows
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hrdata_r <= 32'h0000_0000;
        end
        else if (busSt_r == BUS_RDWAIT)
        begin
            hrdata_r <= 32'h0000_0000;
            if (mapped_r)
            begin
                if (regIdx_r < 6'(dcld_pkg::LATCH_BYTES))
                begin
                    hrdata_r <= {24'h00_0000, latch_r[regIdx_r[1:0]]};
                end
                else if (regHit(regIdx_r, dcld_pkg::IDX_KEY))
                begin
                    hrdata_r <= lockKey_r;
                end
                else if (regHit(regIdx_r, dcld_pkg::IDX_CTRL))
                begin
                    hrdata_r <= {29'h0000_0000, 1'b0, testMode_r, flashProt_r};
                end
                else
                begin
                    hrdata_r <= {26'h000_0000, cfg_r};
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Configuration latch bytes
    // ---------------------------------------------------------------

    // Rewrites are stored but only applied at the next capture
    // Latches refuse rewrites once the applied lock is in force
    generate
        for (genvar i = 0; i < dcld_pkg::LATCH_BYTES; i++)
        begin : g_latch
            localparam logic [7:0] RST_VAL =
                (i == 0) ? dcld_pkg::LATCH0_RESET :
                (i == 1) ? dcld_pkg::LATCH1_RESET :
                (i == 2) ? (dcld_pkg::LATCH2_RESET | (8'(RESET_PIN_DEFAULT) << dcld_pkg::RSTPIN_BIT)) :
                dcld_pkg::LATCH3_RESET;
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    latch_r[i] <= RST_VAL;
                end
                else if (wrStrobe && regHit(regIdx_r, 6'(i)) && !cfg_r.locked)
                begin
                    latch_r[i] <= hwdata[7:0];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Write-once lock latch and protection
    // ---------------------------------------------------------------

    // Once locked the key cannot be rewritten; only arst_n reloads KEY_RESET
    // Key accepted only while unprotected and not yet locked
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lockKey_r <= dcld_pkg::KEY_RESET;
        end
        else if (wrStrobe && regHit(regIdx_r, dcld_pkg::IDX_KEY)
                 && !flashProt_r
                 && !cfg_r.locked)
        begin
            lockKey_r <= hwdata;
        end
    end

    // Flash protection state; frozen once locked
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flashProt_r <= 1'b0;
        end
        else if (wrStrobe && regHit(regIdx_r, dcld_pkg::IDX_CTRL) && !cfg_r.locked)
        begin
            flashProt_r <= hwdata[dcld_pkg::CTRL_PROT];
        end
    end

    // Test mode entry by the programmer; never while locked
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            testMode_r <= 1'b0;
        end
        else if (captureNow)
        begin
            testMode_r <= 1'b0;
        end
        else if (wrStrobe && regHit(regIdx_r, dcld_pkg::IDX_CTRL))
        begin
            testMode_r <= hwdata[dcld_pkg::CTRL_TEST] && !cfg_r.locked;
        end
    end

    // ---------------------------------------------------------------
    // Reset capture of the applied configuration
    // ---------------------------------------------------------------

    // Warm reset via shared pin only when the pin is a reset input
    assign warmResetActive = cfg_r.resetPinSelect && !externalResetN;
    assign softReset       = wrStrobe && regHit(regIdx_r, dcld_pkg::IDX_CTRL)
                             && hwdata[dcld_pkg::CTRL_SOFTRST];
    assign captureNow      = startupPend_r || warmResetActive || softReset;

    // Lock is judged on an exact key match, nothing partial
    // Live decode of the latch bytes
    always_comb
    begin
        cfgLive.resetPinSelect  = latch_r[2][dcld_pkg::RSTPIN_BIT];
        cfgLive.debugEnable     = latch_r[2][dcld_pkg::DEBUGEN_BIT];
        cfgLive.debugPortSelect = dcld_pkg::dcld_port_e'(latch_r[2][dcld_pkg::PORTSEL_LSB +: 2]);
        cfgLive.flashEccEnable  = latch_r[3][dcld_pkg::ECC_BIT];
        cfgLive.locked          = (lockKey_r == dcld_pkg::LOCK_KEY);
    end

    // Models the capture that follows power-on
    // First capture one edge after asynchronous reset release
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startupPend_r <= 1'b1;
        end
        else
        begin
            startupPend_r <= 1'b0;
        end
    end

    // Trade-off: a rewrite costs a reset before it takes effect
    // Applied settings change only at a reset, never on a rewrite
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_r <= '0;
        end
        else if (captureNow)
        begin
            cfg_r <= cfgLive;
        end
    end

    // ---------------------------------------------------------------
    // Decoded outputs
    // ---------------------------------------------------------------

    // Outputs below decode applied state, except test mode, which is the live register
    // Lock blocks every debug port regardless of the selection
    always_comb
    begin
        jtag5Enable = 1'b0;
        jtag4Enable = 1'b0;
        swdEnable   = 1'b0;
        case (cfg_r.debugPortSelect)
            dcld_pkg::PORT_JTAG5:   jtag5Enable = !cfg_r.locked;
            dcld_pkg::PORT_JTAG4:   jtag4Enable = !cfg_r.locked;
            dcld_pkg::PORT_SWD:     swdEnable   = !cfg_r.locked;
            dcld_pkg::PORT_OFF:     swdEnable   = 1'b0;
            default:                swdEnable   = 1'b0;
        endcase
    end

    // Access port granted by debug enable, or by test mode if clear
    assign debugAccessGrant = (cfg_r.debugEnable || testMode_r)
                              && (jtag5Enable || jtag4Enable || swdEnable);
    assign programAllowed   = debugAccessGrant && !cfg_r.locked;
    assign jtagProgramEntry = programAllowed && (jtag5Enable || jtag4Enable);
    assign testModeActive   = testMode_r;
    assign sharedPinGpio    = !cfg_r.resetPinSelect;
    assign appliedCfg       = cfg_r;

    // Bytes per row the programmer must load
    assign rowLoadBytes = cfg_r.flashEccEnable ? dcld_pkg::ROW_CODE : dcld_pkg::ROW_FULL;

endmodule : dcld_config_latch

//--- verilog/dcld_pkg.sv
package dcld_pkg;

    // ---------------------------------------------------------------
    // Register word indices and latch byte count
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_LATCH0  = 6'h00;
    localparam logic [5:0] IDX_LATCH1  = 6'h01;
    localparam logic [5:0] IDX_LATCH2  = 6'h02;
    localparam logic [5:0] IDX_LATCH3  = 6'h03;
    localparam logic [5:0] IDX_KEY     = 6'h04;
    localparam logic [5:0] IDX_CTRL    = 6'h05;
    localparam logic [5:0] IDX_STATUS  = 6'h06;
    localparam int         LATCH_BYTES = 4;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int RSTPIN_BIT   = 7;     // Byte 2
    localparam int DEBUGEN_BIT  = 6;     // Byte 2
    localparam int PORTSEL_LSB  = 4;     // Byte 2, two bits
    localparam int ECC_BIT      = 3;     // Byte 3
    localparam int CTRL_PROT    = 0;
    localparam int CTRL_TEST    = 1;
    localparam int CTRL_SOFTRST = 2;

    // ---------------------------------------------------------------
    // Reset values and constants
    // ---------------------------------------------------------------
    localparam logic [7:0]  LATCH0_RESET  = 8'h00;
    localparam logic [7:0]  LATCH1_RESET  = 8'h00;
    localparam logic [7:0]  LATCH2_RESET  = 8'h50;   // Debug on, 4-wire JTAG
    localparam logic [7:0]  LATCH3_RESET  = 8'h00;   // Spare bytes hold data
    localparam logic [31:0] KEY_RESET     = 32'h0000_0000;
    localparam logic [31:0] LOCK_KEY      = 32'h1234_abcd;  // Arbitrary value
    localparam logic [8:0]  ROW_CODE      = 9'h100;  // 256 code bytes
    localparam logic [8:0]  ROW_FULL      = 9'h120;  // 288 bytes with spare

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PORT_JTAG5 = 2'h0,
        PORT_JTAG4 = 2'h1,
        PORT_SWD   = 2'h2,
        PORT_OFF   = 2'h3
    } dcld_port_e;

    typedef struct packed
    {
        logic      resetPinSelect;
        logic      debugEnable;
        dcld_port_e debugPortSelect;
        logic      flashEccEnable;
        logic      locked;
    } dcld_cfg_s;

endpackage : dcld_pkg

//--- verif/dcld_config_latch_props.sv
module dcld_config_latch_props
(
    input wire logic                ref_clk,
    input wire logic                arst_n,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [2:0]          hsize,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic [31:0]         hrdata,
    input wire logic                hresp,
    input wire logic                externalResetN,
    input wire dcld_pkg::dcld_cfg_s appliedCfg,
    input wire logic                sharedPinGpio,
    input wire logic                warmResetActive,
    input wire logic                jtag5Enable,
    input wire logic                jtag4Enable,
    input wire logic                swdEnable,
    input wire logic                debugAccessGrant,
    input wire logic                programAllowed,
    input wire logic                jtagProgramEntry,
    input wire logic                testModeActive,
    input wire logic [8:0]          rowLoadBytes
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       ctrlWr_r;
    logic [1:0] relCnt_r;
    logic       softRst;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // CTRL write address phase taken, so the next data phase may soft reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrlWr_r <= 1'b0;
        else if (hready)
            ctrlWr_r <= hsel && htrans[1] && hwrite && haddr == 32'h14;
    end

    // Two edges of grace: the capture after release shows up one edge late
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            relCnt_r <= 2'h0;
        else if (relCnt_r != 2'h2)
            relCnt_r <= relCnt_r + 2'h1;
    end

    assign softRst = ctrlWr_r && hwdata[2];

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    a_pin_mode:
        assert property (sharedPinGpio == !appliedCfg.resetPinSelect)
        else $error("shared pin mode wrong");
    a_warm_reset:
        assert property (warmResetActive == (appliedCfg.resetPinSelect && !externalResetN))
        else $error("warm reset level wrong");
    a_port_decode:
        assert property (!appliedCfg.locked |-> {jtag5Enable, jtag4Enable, swdEnable} == (3'h4 >> appliedCfg.debugPortSelect))
        else $error("port decode wrong");
    a_prog_entry:
        assert property (jtagProgramEntry == (programAllowed && (jtag5Enable || jtag4Enable)))
        else $error("jtag entry wrong");
    a_dap_grant:
        assert property (debugAccessGrant == ((appliedCfg.debugEnable || testModeActive) && (jtag5Enable || jtag4Enable || swdEnable)))
        else $error("debug access grant wrong");
    a_row_bytes:
        assert property (rowLoadBytes == (appliedCfg.flashEccEnable ? dcld_pkg::ROW_CODE : dcld_pkg::ROW_FULL))
        else $error("row byte count wrong");
    a_lock_out:
        assert property (appliedCfg.locked |-> !(jtag5Enable || jtag4Enable || swdEnable || programAllowed || testModeActive))
        else $error("locked part still open");
    a_lock_keep:
        assert property ($past(appliedCfg.locked) |-> appliedCfg.locked)
        else $error("lock dropped");
    a_cfg_hold:
        assert property (!$stable(appliedCfg) |-> relCnt_r != 2'h2 || $past(warmResetActive) || $past(softRst))
        else $error("config changed without a reset");
endmodule : dcld_config_latch_props

bind dcld_config_latch dcld_config_latch_props props_u
(
    .ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .externalResetN, .appliedCfg, .sharedPinGpio, .warmResetActive, .jtag5Enable, .jtag4Enable, .swdEnable,
    .debugAccessGrant, .programAllowed, .jtagProgramEntry, .testModeActive, .rowLoadBytes
);

//--- verif/dcld_host_model.sv
module dcld_host_model
(
    input wire logic   ref_clk,
    input wire logic   hready,
    input wire logic [31:0] hrdata,
    output logic       hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic       hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle at time zero
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Single word transfer; ready and read data taken at rising edges
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do
        begin
            @(posedge ref_clk);
        end
        while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(posedge ref_clk);
        end
        while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
endmodule : dcld_host_model

//--- verif/dcld_tb.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                ref_clk = 1'b0;
    logic                arst_n = 1'b0;
    logic                externalResetN = 1'b1;
    logic                hsel, hwrite, hreadyout, hresp, sharedPinGpio, warmResetActive;
    logic                jtag5Enable, jtag4Enable, swdEnable, debugAccessGrant;
    logic                programAllowed, jtagProgramEntry, testModeActive;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [8:0]          rowLoadBytes;
    logic [31:0]         haddr, hwdata, hrdata;
    logic [7:0]          pins;
    dcld_pkg::dcld_cfg_s appliedCfg;
    int                  n_mismatch = 0;
    int                  checks_done = 0;
    int                  cyc = 0;

    always #25 ref_clk = ~ref_clk;

    dcld_config_latch dut_u (.ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .externalResetN, .appliedCfg, .sharedPinGpio,
        .warmResetActive, .jtag5Enable, .jtag4Enable, .swdEnable, .debugAccessGrant, .programAllowed,
        .jtagProgramEntry, .testModeActive, .rowLoadBytes);
    dcld_host_model host_u (.ref_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata);

    // Decoded outputs gathered for one compare
    assign pins = {sharedPinGpio, jtag5Enable, jtag4Enable, swdEnable, debugAccessGrant, programAllowed,
        jtagProgramEntry, testModeActive};

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk_reg(string name, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask : chk_reg

    // Outputs settle by mid-cycle
    task automatic chk_out(string name, logic [7:0] exp);
        @(negedge ref_clk);
        chk_reg(name, {24'h0, exp}, {24'h0, pins});
    endtask : chk_out

    task automatic wr(logic [5:0] idx, logic [31:0] d);
        logic [31:0] x;
        host_u.xfer(1'b1, idx, d, x);
    endtask : wr

    task automatic rdchk(string name, logic [5:0] idx, logic [31:0] exp);
        logic [31:0] x;
        host_u.xfer(1'b0, idx, 32'h0, x);
        chk_reg(name, exp, x);
        chk_reg("hresp", 32'h0, {31'h0, hresp});
    endtask : rdchk

    task automatic stop_test();
        $display("TB: checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_defaults();
        rdchk("latch2", dcld_pkg::IDX_LATCH2, {24'h0, dcld_pkg::LATCH2_RESET});
        rdchk("latch3", dcld_pkg::IDX_LATCH3, 32'h0);
        rdchk("key", dcld_pkg::IDX_KEY, dcld_pkg::KEY_RESET);
        rdchk("status", dcld_pkg::IDX_STATUS, 32'h14);
        rdchk("unmapped", 6'h3f, 32'h0);
        chk_out("pins", 8'hae);
        chk_reg("applied", 32'h14, {26'h0, appliedCfg});
        chk_reg("rows", 32'h120, {23'h0, rowLoadBytes});
        $display("TB: defaults done");
    endtask : t_defaults

    // Every port select code, applied by soft reset
    task automatic t_dps();
        logic [7:0] expPins [4] = '{8'hce, 8'hae, 8'h9c, 8'h80};
        for (int i = 0; i < 4; i++)
        begin
            wr(dcld_pkg::IDX_LATCH2, {24'h0, 2'h1, i[1:0], 4'h0});
            wr(dcld_pkg::IDX_CTRL, 32'h4);
            chk_out("dps pins", expPins[i]);
        end
        $display("TB: port select done");
    endtask : t_dps

    task automatic t_debug();
        wr(dcld_pkg::IDX_LATCH2, 32'h10);
        wr(dcld_pkg::IDX_CTRL, 32'h4);
        chk_out("no debug", 8'ha0);
        wr(dcld_pkg::IDX_CTRL, 32'h2);
        chk_out("test mode", 8'haf);
        rdchk("ctrl", dcld_pkg::IDX_CTRL, 32'h2);
        wr(dcld_pkg::IDX_CTRL, 32'h4);
        chk_out("test cleared", 8'ha0);
        $display("TB: debug done");
    endtask : t_debug

    // Rewritten latches must not leak out before the pin reset
    task automatic t_ecc_pin();
        wr(dcld_pkg::IDX_LATCH3, 32'h8);
        wr(dcld_pkg::IDX_LATCH2, 32'hd0);
        wr(dcld_pkg::IDX_CTRL, 32'h4);
        chk_out("reset pin", 8'h2e);
        chk_reg("ecc rows", 32'h100, {23'h0, rowLoadBytes});
        wr(dcld_pkg::IDX_LATCH3, 32'h0);
        wr(dcld_pkg::IDX_LATCH2, 32'h50);
        chk_out("held", 8'h2e);
        @(posedge ref_clk);
        externalResetN <= 1'b0;
        @(negedge ref_clk);
        chk_reg("warm", 32'h1, {31'h0, warmResetActive});
        @(posedge ref_clk);
        externalResetN <= 1'b1;
        chk_out("after pin", 8'hae);
        chk_reg("rows", 32'h120, {23'h0, rowLoadBytes});
        $display("TB: ecc and pin done");
    endtask : t_ecc_pin

    task automatic t_lock();
        wr(dcld_pkg::IDX_KEY, dcld_pkg::LOCK_KEY);
        wr(dcld_pkg::IDX_CTRL, 32'h1);
        wr(dcld_pkg::IDX_KEY, 32'h0);
        rdchk("key kept", dcld_pkg::IDX_KEY, dcld_pkg::LOCK_KEY);
        chk_out("not yet", 8'hae);
        wr(dcld_pkg::IDX_CTRL, 32'h4);
        chk_out("locked", 8'h80);
        chk_reg("applied", 32'h15, {26'h0, appliedCfg});
        rdchk("status", dcld_pkg::IDX_STATUS, 32'h15);
        wr(dcld_pkg::IDX_LATCH2, 32'hd0);
        rdchk("latch2 frozen", dcld_pkg::IDX_LATCH2, 32'h50);
        wr(dcld_pkg::IDX_KEY, 32'h0);
        rdchk("key frozen", dcld_pkg::IDX_KEY, dcld_pkg::LOCK_KEY);
        wr(dcld_pkg::IDX_CTRL, 32'h2);
        chk_out("no test", 8'h80);
        $display("TB: lock done");
    endtask : t_lock

    // Hang guard: the run needs fewer than 200 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_defaults();
        t_dps();
        t_debug();
        t_ecc_pin();
        t_lock();
        stop_test();
    end
endmodule : testbench
